//--- common/fts_regs.vh
// Register offsets, reset values and field positions of the fan speed target and limit block.
`ifndef FTS_REGS_VH
`define FTS_REGS_VH
`define FTS_ADDR_W 8
`define FTS_OFF_SLOW_LO 8'h10
`define FTS_OFF_SLOW_HI 8'h11
`define FTS_OFF_FAST_LO 8'h12
`define FTS_OFF_FAST_HI 8'h13
`define FTS_OFF_TGT_LO 8'h1e
`define FTS_OFF_TGT_HI 8'h1f
`define FTS_OFF_MEAS_LO 8'h08
`define FTS_OFF_MEAS_HI 8'h09
`define FTS_RST_SLOW 8'hff
`define FTS_RST_FAST 8'h00
`define FTS_RST_TGT 8'hff
`define FTS_LOOP_MODE_BIT 1
`endif

//--- dv/fts_fan_model.sv
// Behavioural fan tachometer handing over measured revolution periods.
`timescale 1ns/1ps
module fts_fan (input wire clock, output reg [15:0] period, output reg valid);
  initial begin period = 16'h0000; valid = 1'b0; end
  // One revolution count per pulse, then time for the flags to settle.
  task send(input [15:0] p);
    @(posedge clock) begin period <= p; valid <= 1'b1; end
    @(posedge clock) valid <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
endmodule

//--- dv/fts_limits_bench.sv
// Self-checking bench for the fan speed target and limit block.
`timescale 1ns/1ps
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module fts_limits_bench;
  reg clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, loop_mode = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata; wire [15:0] meas_period, speed_target;
  wire meas_valid, too_slow, too_fast, speed_fault;
  int fail_count = 0, check_count = 0;
  always #2.5 clock = ~clock;
  fts_limits DUT (.*);
  fts_fan fan (.clock(clock), .period(meas_period), .valid(meas_valid));
  task wr(input [7:0] a, d);
    @(posedge clock) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge clock) reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, e);
    @(posedge clock) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge clock) reg_rd <= 1'b0;
    #1 `CHK("rdata", e, reg_rdata)
  endtask
  // Reset values, with an unmapped place among them that reads as zero.
  task t_reset;
    rd(8'h11, 8'hff);
    rd(8'h13, 8'h00);
    rd(8'h1e, 8'hff);
    rd(8'h40, 8'h00);
    rd(8'h10, 8'hff);
    rd(8'h12, 8'h00);
    rd(8'h1f, 8'hff);
    `CHK("target", 16'hffff, speed_target)
    `CHK("fault", 1'b0, speed_fault)
  endtask
  // A second reset in mid-run must bring every register back to its default.
  task t_rerun;
    wr(8'h10, 8'h55);
    @(posedge clock) rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
  endtask
  // Byte writes build the target period one half at a time.
  task t_target;
    @(posedge clock) loop_mode <= 1'b0;
    wr(8'h1e, 8'h34);
    loop_mode <= 1'b1;
    #1 `CHK("target", 16'hff34, speed_target)
    wr(8'h1f, 8'h12);
    #1 `CHK("target", 16'h1234, speed_target)
    rd(8'h1f, 8'h12);
  endtask
  // Limits at 0x1000 and 0x0800, probed on both sides of each bound.
  task t_limits;
    wr(8'h11, 8'h10); wr(8'h10, 8'h00); wr(8'h13, 8'h08);
    fan.send(16'h1001); #1 `CHK("slow", 1'b1, too_slow)
    fan.send(16'h1000); #1 `CHK("slow", 1'b0, too_slow)
    fan.send(16'h0800); #1 `CHK("fast", 1'b0, too_fast)
    `CHK("fault", 1'b0, speed_fault)
    fan.send(16'h07ff); #1 `CHK("fast", 1'b1, too_fast)
    `CHK("fault", 1'b1, speed_fault)
  endtask
  // A new count between the two byte reads must not reach the high byte.
  task t_freeze;
    fan.send(16'hffff); rd(8'h08, 8'hff);
    fan.send(16'h0000); rd(8'h09, 8'hff);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset; t_target; t_limits; t_freeze; t_rerun;
    complete_run;
  end
endmodule

//--- dv/fts_limits_chk.sv
// Assertion checker for the fan speed target and limit block.
`timescale 1ns/1ps
module fts_chk (input wire clock, rst_n, reg_wr, reg_rd, meas_valid,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata, input wire [15:0] meas_period,
  speed_target, input wire too_slow, too_fast, speed_fault);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_flt; speed_fault == (too_slow | too_fast); endproperty
  a_flt: assert property (p_flt) else $error("fault flag");
  property p_tl; reg_wr && reg_addr == 8'h1e |=> speed_target[7:0] == $past(reg_wdata); endproperty
  a_tl: assert property (p_tl) else $error("target low");
  property p_th; reg_wr && reg_addr == 8'h1f |=> speed_target[15:8] == $past(reg_wdata); endproperty
  a_th: assert property (p_th) else $error("target high");
  property p_keep; reg_wr && reg_addr == 8'h1e |=> $stable(speed_target[15:8]); endproperty
  a_keep: assert property (p_keep) else $error("byte kept");
  property p_hold; !reg_wr |=> $stable(speed_target); endproperty
  a_hold: assert property (p_hold) else $error("target hold");
  property p_rd; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read hold");
  property p_ns; meas_valid && meas_period == 16'h0000 |-> ##2 !too_slow; endproperty
  a_ns: assert property (p_ns) else $error("slow flag");
  property p_nf; meas_valid && meas_period == 16'hffff |-> ##2 !too_fast; endproperty
  a_nf: assert property (p_nf) else $error("fast flag");
  c_slow: cover property (too_slow);
  c_fast: cover property (too_fast);
  c_meas: cover property (reg_rd && reg_addr == 8'h08);
endmodule
bind fts_limits fts_chk chk (.*);

//--- hw/fts_limits.v
// Fan speed target period and slow/fast limit registers with period comparison.
`timescale 1ns/1ps
`include "fts_regs.vh"
// Operation
// - Target low byte at 0x1e, resets 0xff.
// - Target high byte at 0x1f, resets 0xff.
// - Target is revolution period in clock pulses.
// - Host-mode speed target is the written value.
// - Slow limit at 0x10/0x11, resets 0xff.
// - Period above slow limit means too slow.
// - Fast limit at 0x12/0x13, resets 0x00.
// - Period below fast limit means too fast.
// - Measured period is pulses per revolution.
// - Low byte read freezes high byte.
module fts_limits (
  input wire clock,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [15:0] meas_period,
  input wire meas_valid,
  input wire loop_mode,
  output wire [15:0] speed_target,
  output reg too_slow,
  output reg too_fast,
  output wire speed_fault
);

  // ****************************************
  // Register storage
  // ****************************************

  // Indices of the six byte registers inside the storage vector.
  localparam [2:0] IDX_SLOW_LO = 3'd0;
  localparam [2:0] IDX_SLOW_HI = 3'd1;
  localparam [2:0] IDX_FAST_LO = 3'd2;
  localparam [2:0] IDX_FAST_HI = 3'd3;
  localparam [2:0] IDX_TGT_LO = 3'd4;
  localparam [2:0] IDX_TGT_HI = 3'd5;
  localparam [2:0] IDX_NONE = 3'd7;

  // Number of byte registers held by this block.
  localparam integer NUM_BYTES = 6;

  // All six byte registers side by side; byte i sits in bits 8*i+7 down to 8*i.
  wire [8*NUM_BYTES-1:0] bytes_w;

  // Measured period, the paired high-byte copy and the freeze state.
  reg [15:0] meas_r;
  reg [15:0] meas_nxt;
  reg [7:0] meas_hi_hold_r;
  reg [7:0] meas_hi_hold_nxt;
  reg freeze_r;
  reg freeze_nxt;

  // Next values of the comparison flags and of the read data.
  reg too_slow_nxt;
  reg too_fast_nxt;
  reg [7:0] rdata_nxt;

  // ****************************************
  // Decoding functions
  // ****************************************

  // Maps a bus address to a byte register index, or IDX_NONE when unmapped.
  function [2:0] fts_index;
    input [7:0] addr;
    begin
      case (addr)
        `FTS_OFF_SLOW_LO: fts_index = IDX_SLOW_LO;
        `FTS_OFF_SLOW_HI: fts_index = IDX_SLOW_HI;
        `FTS_OFF_FAST_LO: fts_index = IDX_FAST_LO;
        `FTS_OFF_FAST_HI: fts_index = IDX_FAST_HI;
        `FTS_OFF_TGT_LO: fts_index = IDX_TGT_LO;
        `FTS_OFF_TGT_HI: fts_index = IDX_TGT_HI;
        default: fts_index = IDX_NONE;
      endcase
    end
  endfunction

  // Picks one byte out of the storage vector by its index.
  function [7:0] fts_byte;
    input [8*NUM_BYTES-1:0] vec;
    input [2:0] idx;
    begin
      fts_byte = vec[idx*8 +: 8];
    end
  endfunction

  // ****************************************
  // Access decode
  // ****************************************

  // The same index serves writes and reads; the two measured-period
  // addresses are decoded apart because they are read-only.
  wire [2:0] acc_idx = fts_index(reg_addr);
  wire acc_hit = (acc_idx != IDX_NONE);
  wire rd_meas_lo = reg_rd && (reg_addr == `FTS_OFF_MEAS_LO);
  wire rd_meas_hi = reg_rd && (reg_addr == `FTS_OFF_MEAS_HI);

  // ****************************************
  // Byte registers
  // ****************************************

  // Each byte register loads only when its own address is written, so a
  // write to one half of a pair never disturbs the other half.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTES; gi = gi + 1) begin : g_byte
      localparam [7:0] RST_VAL = (gi < 2) ? `FTS_RST_SLOW :
                                 (gi < 4) ? `FTS_RST_FAST :
                                 `FTS_RST_TGT;
      wire wr_hit = reg_wr && ({29'd0, acc_idx} == gi);
      reg [7:0] val_r;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          val_r <= RST_VAL;
        end else if (wr_hit) begin
          val_r <= reg_wdata;
        end
      end
      assign bytes_w[8*gi +: 8] = val_r;
    end
  endgenerate

  // Both limits are assembled from their two bytes before any compare.
  wire [15:0] slow_limit = {fts_byte(bytes_w, IDX_SLOW_HI), fts_byte(bytes_w, IDX_SLOW_LO)};
  wire [15:0] fast_limit = {fts_byte(bytes_w, IDX_FAST_HI), fts_byte(bytes_w, IDX_FAST_LO)};

  // The written period is handed straight to the speed loop as its target.
  assign speed_target = {fts_byte(bytes_w, IDX_TGT_HI), fts_byte(bytes_w, IDX_TGT_LO)};

  // ****************************************
  // Measured period and read coherency
  // ****************************************

  // Takes each completed revolution count as the new measured period.
  always @* begin
    meas_nxt = meas_r;
    if (meas_valid) begin
      meas_nxt = meas_period;
    end
  end

  // A low-byte read copies the high byte and freezes it; the high-byte read
  // releases it, so a count arriving between the two reads cannot tear them.
  always @* begin
    meas_hi_hold_nxt = meas_hi_hold_r;
    freeze_nxt = freeze_r;
    if (rd_meas_lo) begin
      meas_hi_hold_nxt = meas_r[15:8];
      freeze_nxt = 1'b1;
    end else if (rd_meas_hi) begin
      freeze_nxt = 1'b0;
    end
  end

  // ****************************************
  // Limit comparison
  // ****************************************

  // Compares the stored period against the full 16-bit limits, strictly.
  always @* begin
    too_slow_nxt = (meas_r > slow_limit);
    too_fast_nxt = (meas_r < fast_limit);
  end

  // Either out-of-range condition raises the fault flag.
  assign speed_fault = too_slow | too_fast;

  // ****************************************
  // Read data
  // ****************************************

  // Selects the read data; unmapped addresses read as zero and the value
  // stands until the next read.
  always @* begin
    rdata_nxt = reg_rdata;
    if (reg_rd) begin
      if (acc_hit) begin
        rdata_nxt = fts_byte(bytes_w, acc_idx);
      end else if (reg_addr == `FTS_OFF_MEAS_LO) begin
        rdata_nxt = meas_r[7:0];
      end else if (reg_addr == `FTS_OFF_MEAS_HI) begin
        rdata_nxt = freeze_r ? meas_hi_hold_r : meas_r[15:8];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************

  // Holds the measurement, freeze state, flags and read data.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meas_r <= 16'h0000;
      meas_hi_hold_r <= 8'h00;
      freeze_r <= 1'b0;
      too_slow <= 1'b0;
      too_fast <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      meas_r <= meas_nxt;
      meas_hi_hold_r <= meas_hi_hold_nxt;
      freeze_r <= freeze_nxt;
      too_slow <= too_slow_nxt;
      too_fast <= too_fast_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

endmodule
